/* File: verilog/serial_port_consts.vh */
// Constants for the serial port register map and baud rate generator.
// Overview of operation
// - Transmit pin idles high in both modes.
// - Transmit pin floats while transmitter off.
// - Receive pin high means idle line.
// - Receive pin ignored while receiver off.
// - Registers decode at base plus offsets 0-9.
// - Reserved locations ignore writes, read zero.
// - Bank bit selects divisor or alternate registers.
// - Bank bit resets to zero.
// - Divisor upper byte 0, lower byte 1.
// - Normal mode: rate is clock over divisor.
// - Infrared: rate is clock over twice divisor[15:1].
// - Generator idle until first tx/rx enable.
// - Generator stops on too-small divisor.
// - New divisor loads at next sample period.
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_DIV_UPPER    3'h0
`define OFS_DIV_LOWER    3'h1
`define OFS_CTRL_ONE     3'h2
`define OFS_ENABLE_CTRL  3'h3
`define OFS_STATUS_ONE   3'h4
`define OFS_STATUS_TWO   3'h5
`define OFS_DATA_HIGH    3'h6
`define OFS_DATA_LOW     3'h7
`define OFS_IRQ_STATUS   4'h8
`define OFS_IRQ_MASK     4'h9

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_TX_ON        3
`define BIT_RX_ON        2
`define BIT_BANK_SELECT  7
`define BIT_INFRARED     7
`define BIT_IRQ_PERIOD   0
`define BIT_IRQ_RXEDGE   1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_DIV_UPPER    8'h00
`define RST_DIV_LOWER    8'h40
`define RST_BYTE         8'h00
`define RST_IRQ          2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define SAMPLES_PER_BIT  5'h10
`endif

/* File: verilog/serial_port_regmap.v */
// Register map, pin behaviour and baud rate generator of the serial port.
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_consts.vh"

module serial_port_regmap (
    input  wire       mclk_i,
    input  wire       rstn_i,
    input  wire       ce_i,
    input  wire [3:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    input  wire       rxd_i,
    output reg  [7:0] rdata_o,
    output reg        txd_o,
    output reg        txd_oen_o,
    output reg        rx_line_o,
    output reg        rx_sample_clock_o,
    output reg        baud_tick_o,
    output reg        irq_o
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg  [7:0]  div_upper_q;
    reg  [7:0]  div_lower_q;
    reg  [7:0]  ctrl_one_q;
    reg  [7:0]  alt_ctrl_one_q;
    reg  [7:0]  alt_ctrl_two_q;
    reg  [7:0]  enable_ctrl_q;
    reg         bank_select_q;
    reg  [7:0]  tx_data_q;
    reg         tx_ninth_q;
    reg  [1:0]  irq_status_q;
    reg  [1:0]  irq_mask_q;
    reg         gen_started_q;
    reg  [15:0] active_div_q;
    reg         active_ir_q;
    reg  [15:0] rt_count_q;
    reg  [4:0]  bit_count_q;
    reg         rx_prev_q;
    reg  [7:0]  rdata_d;
    reg  [1:0]  irq_status_d;

    wire        tx_on;
    wire        rx_on;
    wire        infrared_mode_on;
    wire [15:0] baud_divisor;
    wire        gen_stop;
    wire [15:0] rt_limit;
    wire        rt_wrap;
    wire        bit_wrap;
    wire        rx_edge;

    assign tx_on            = enable_ctrl_q[`BIT_TX_ON];
    assign rx_on            = enable_ctrl_q[`BIT_RX_ON];
    assign infrared_mode_on = alt_ctrl_two_q[`BIT_INFRARED];
    assign baud_divisor     = {div_upper_q, div_lower_q};

    // Returns high when a write strobe hits the given offset.
    function wr_hit;
        input [3:0] a;
        input       w;
        input [3:0] ofs;
        begin
            wr_hit = w && (a == ofs);
        end
    endfunction

    // ----------------------------------------
    // Baud divider arithmetic
    // ----------------------------------------
    // Sample period counts a sixteenth of the bit time. In infrared mode bit 0 is dropped and
    // the rest counts double, so twice divisor[15:1] over sixteen is again divisor[15:4].
    assign rt_limit = {4'b0000, active_div_q[15:4]};
    assign gen_stop = active_ir_q ? (active_div_q[15:5] == 11'h000)
                                  : (active_div_q[15:4] == 12'h000);
    assign rt_wrap  = (rt_count_q == 16'h0000);
    assign bit_wrap = rt_wrap && (bit_count_q == 5'h00);
    assign rx_edge  = rx_on && rx_prev_q && !rxd_i;

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    // Bank bit steers the three lowest offsets to either the divisor and control one, or the alternate set at offsets 1 and 2.
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_upper_q    <= `RST_DIV_UPPER;
            div_lower_q    <= `RST_DIV_LOWER;
            ctrl_one_q     <= `RST_BYTE;
            alt_ctrl_one_q <= `RST_BYTE;
            alt_ctrl_two_q <= `RST_BYTE;
            enable_ctrl_q  <= `RST_BYTE;
            bank_select_q  <= 1'b0;
            tx_data_q      <= `RST_BYTE;
            tx_ninth_q     <= 1'b0;
            irq_mask_q     <= `RST_IRQ;
        end else if (ce_i) begin
            if (!bank_select_q) begin
                if (wr_hit(addr_i, wr_i, {1'b0, `OFS_DIV_UPPER}))
                    div_upper_q <= wdata_i;
                if (wr_hit(addr_i, wr_i, {1'b0, `OFS_DIV_LOWER}))
                    div_lower_q <= wdata_i;
                if (wr_hit(addr_i, wr_i, {1'b0, `OFS_CTRL_ONE}))
                    ctrl_one_q <= wdata_i;
            end else begin
                if (wr_hit(addr_i, wr_i, {1'b0, `OFS_DIV_LOWER}))
                    alt_ctrl_one_q <= wdata_i & 8'h83;
                if (wr_hit(addr_i, wr_i, {1'b0, `OFS_CTRL_ONE}))
                    alt_ctrl_two_q <= wdata_i & 8'hE7;
            end
            if (wr_hit(addr_i, wr_i, {1'b0, `OFS_ENABLE_CTRL}))
                enable_ctrl_q <= wdata_i;
            if (wr_hit(addr_i, wr_i, {1'b0, `OFS_STATUS_TWO}))
                bank_select_q <= wdata_i[`BIT_BANK_SELECT];
            if (wr_hit(addr_i, wr_i, {1'b0, `OFS_DATA_HIGH}))
                tx_ninth_q <= wdata_i[6];
            if (wr_hit(addr_i, wr_i, {1'b0, `OFS_DATA_LOW}))
                tx_data_q <= wdata_i;
            if (wr_hit(addr_i, wr_i, `OFS_IRQ_MASK))
                irq_mask_q <= wdata_i[1:0];
        end
    end

    // ----------------------------------------
    // Baud rate generator
    // ----------------------------------------
    // Stays idle until a first enable, then reloads divisor only at a sample period boundary.
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gen_started_q     <= 1'b0;
            active_div_q      <= {`RST_DIV_UPPER, `RST_DIV_LOWER};
            active_ir_q       <= 1'b0;
            rt_count_q        <= 16'h0000;
            bit_count_q       <= 5'h00;
            rx_sample_clock_o <= 1'b0;
            baud_tick_o       <= 1'b0;
        end else if (ce_i) begin
            rx_sample_clock_o <= 1'b0;
            baud_tick_o       <= 1'b0;
            if (tx_on || rx_on)
                gen_started_q <= 1'b1;
            if (!gen_started_q) begin
                active_div_q <= baud_divisor;
                active_ir_q  <= infrared_mode_on;
                rt_count_q   <= 16'h0000;
                bit_count_q  <= 5'h00;
            end else if (rt_wrap) begin
                // Once started, fresh divisor is taken only here, so a mid-period write cannot glitch timing.
                active_div_q <= baud_divisor;
                active_ir_q  <= infrared_mode_on;
                if (!gen_stop) begin
                    rt_count_q        <= rt_limit - 16'h0001;
                    rx_sample_clock_o <= 1'b1;
                    bit_count_q       <= bit_wrap ? (`SAMPLES_PER_BIT - 5'h01)
                                                  : (bit_count_q - 5'h01);
                    baud_tick_o       <= bit_wrap;
                end
            end else begin
                rt_count_q <= rt_count_q - 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // Pins
    // ----------------------------------------
    // Transmit pin drives idle high when on and floats when off; enable is active low.
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            txd_o     <= 1'b1;
            txd_oen_o <= 1'b1;
            rx_line_o <= 1'b1;
            rx_prev_q <= 1'b1;
        end else if (ce_i) begin
            txd_o     <= 1'b1;
            txd_oen_o <= !tx_on;
            rx_line_o <= rx_on ? rxd_i : 1'b1;
            rx_prev_q <= rx_on ? rxd_i : 1'b1;
        end
    end

    // ----------------------------------------
    // Interrupt status
    // ----------------------------------------
    // Hardware set wins over a write-one clear in the same cycle.
    always @* begin
        irq_status_d = irq_status_q;
        if (wr_hit(addr_i, wr_i, `OFS_IRQ_STATUS))
            irq_status_d = irq_status_q & ~wdata_i[1:0];
        if (baud_tick_o)
            irq_status_d[`BIT_IRQ_PERIOD] = 1'b1;
        if (rx_edge)
            irq_status_d[`BIT_IRQ_RXEDGE] = 1'b1;
    end

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_status_q <= `RST_IRQ;
            irq_o        <= 1'b0;
        end else if (ce_i) begin
            irq_status_q <= irq_status_d;
            irq_o        <= |(irq_status_d & irq_mask_q);
        end
    end

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    // Reserved and unmapped offsets read as zero.
    always @* begin
        rdata_d = 8'h00;
        case (addr_i)
            {1'b0, `OFS_DIV_UPPER}:   rdata_d = bank_select_q ? 8'h00 : div_upper_q;
            {1'b0, `OFS_DIV_LOWER}:   rdata_d = bank_select_q ? alt_ctrl_one_q : div_lower_q;
            {1'b0, `OFS_CTRL_ONE}:    rdata_d = bank_select_q ? alt_ctrl_two_q : ctrl_one_q;
            {1'b0, `OFS_ENABLE_CTRL}: rdata_d = enable_ctrl_q;
            {1'b0, `OFS_STATUS_ONE}:  rdata_d = {1'b1, 3'b000, !rx_line_o, 3'b000};
            {1'b0, `OFS_STATUS_TWO}:  rdata_d = {bank_select_q, 7'h00};
            {1'b0, `OFS_DATA_HIGH}:   rdata_d = {1'b0, tx_ninth_q, 6'h00};
            {1'b0, `OFS_DATA_LOW}:    rdata_d = 8'h00;
            `OFS_IRQ_STATUS:          rdata_d = {6'h00, irq_status_q};
            `OFS_IRQ_MASK:            rdata_d = {6'h00, irq_mask_q};
            default:                  rdata_d = 8'h00;
        endcase
    end

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i)
            rdata_o <= 8'h00;
        else if (ce_i)
            rdata_o <= rd_i ? rdata_d : 8'h00;
    end

endmodule
`default_nettype wire

/* File: verif/serial_port_regmap_asserts.sv */
// Port-level checker for the serial port register block.
`timescale 1ns/100ps
`default_nettype none
module serial_port_regmap_checker (
    input wire logic       mclk_i,
    input wire logic       rstn_i,
    input wire logic       ce_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic       rxd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       txd_o,
    input wire logic       txd_oen_o,
    input wire logic       rx_line_o,
    input wire logic       rx_sample_clock_o,
    input wire logic       baud_tick_o,
    input wire logic       irq_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    logic tx_q;
    logic rx_q;
    logic seen_q;
    // Shadow the enable bits so pin behaviour can be tied to the last write.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_q   <= 1'b0;
            rx_q   <= 1'b0;
            seen_q <= 1'b0;
        end else if (ce_i && wr_i && addr_i == 4'h3) begin
            tx_q   <= wdata_i[3];
            rx_q   <= wdata_i[2];
            seen_q <= seen_q | wdata_i[3] | wdata_i[2];
        end
    end
    tx_idle_a: assert property (txd_o) else $error("tx pin not idle");
    tx_float_a: assert property (txd_oen_o == !$past(tx_q)) else $error("tx enable");
    rx_idle_a: assert property ($past(!rx_q || rxd_i) |-> rx_line_o)
        else $error("rx line not idle");
    rd_quiet_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside slot");
    rd_resv_a: assert property ($past(rd_i && addr_i > 4'h9) |-> rdata_o == 8'h00)
        else $error("reserved read not zero");
    rd_stat_a: assert property ($past(rd_i && addr_i == 4'h4) |-> rdata_o[7])
        else $error("status one bit7 low");
    gen_idle_a: assert property (!$past(seen_q) |-> !rx_sample_clock_o)
        else $error("sample pulse before enable");
    tick_gap_a: assert property (baud_tick_o |=> !baud_tick_o [*8])
        else $error("bit ticks too close");
    cover property (baud_tick_o);
    cover property (irq_o);
    cover property (!rx_line_o);
endmodule
bind serial_port_regmap serial_port_regmap_checker i_chk (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rxd_i(rxd_i), .rdata_o(rdata_o), .txd_o(txd_o),
    .txd_oen_o(txd_oen_o), .rx_line_o(rx_line_o), .rx_sample_clock_o(rx_sample_clock_o),
    .baud_tick_o(baud_tick_o), .irq_o(irq_o));
`default_nettype wire

/* File: verif/serial_peer.sv */
// Behavioural model of the remote serial peer on the two pins.
`timescale 1ns/100ps
`default_nettype none
module serial_peer (
    input  wire logic mclk_i,
    input  wire logic txd_o,
    input  wire logic txd_oen_o,
    output var logic  rxd_o
);
    wire tx_wire;
    // A floating transmit pin is pulled up by the line termination.
    assign tx_wire = txd_oen_o ? 1'b1 : txd_o;
    // The peer idles its line high and changes it just after an edge.
    initial begin
        rxd_o = 1'b1;
    end
    task automatic drive(input logic v);
        @(posedge mclk_i);
        rxd_o <= v;
    endtask
endmodule
`default_nettype wire

/* File: verif/serial_port_regmap_baud_gen_tb_top.sv */
// Self-checking testbench for the serial port register block.
`timescale 1ns/100ps
`default_nettype none
module serial_port_regmap_baud_gen_tb_top;
    logic       mclk_i = 1'b0;
    logic       rstn_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic [7:0] v;
    wire        rxd_i, txd_o, txd_oen_o, rx_line_o, rx_sample_clock_o, baud_tick_o, irq_o;
    wire  [7:0] rdata_o;
    int         n_mismatch = 0;
    int         num_checks = 0;
    int         t0, t1;
    serial_port_regmap i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(1'b1), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rxd_i(rxd_i), .rdata_o(rdata_o),
        .txd_o(txd_o), .txd_oen_o(txd_oen_o), .rx_line_o(rx_line_o),
        .rx_sample_clock_o(rx_sample_clock_o), .baud_tick_o(baud_tick_o), .irq_o(irq_o));
    serial_peer i_peer (.mclk_i(mclk_i), .txd_o(txd_o), .txd_oen_o(txd_oen_o), .rxd_o(rxd_i));
    // Free-running 25 MHz clock.
    initial begin
        forever #20 mclk_i = ~mclk_i;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    // Read data are taken at the edge that closes their one-cycle slot.
    task automatic rd(input logic [3:0] a);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(posedge mclk_i);
        v = rdata_o;
    endtask
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (baud_tick_o !== 1'b1 && n < 600);
    endtask
    task automatic t_regs;
        rd(4'h1); check(v, 8'h40);
        rd(4'h5); check(v, 8'h00);
        wr(4'hc, 8'hff);
        rd(4'hc); check(v, 8'h00);
        wr(4'h0, 8'h12);
        wr(4'h1, 8'h34);
        rd(4'h0); check(v, 8'h12);
        wr(4'h5, 8'h80);
        rd(4'h0); check(v, 8'h00);
        wr(4'h2, 8'hff);
        rd(4'h2); check(v, 8'he7);
        wr(4'h5, 8'h00);
        rd(4'h2); check(v, 8'h00);
        rd(4'h1); check(v, 8'h34);
        $display("regs test done");
    endtask
    task automatic t_rate;
        wr(4'h0, 8'h00);
        wr(4'h1, 8'h80);
        wait_tick(t0); check(t0, 600);
        wr(4'h3, 8'h08);
        wait_tick(t0); wait_tick(t1); check(t1, 128);
        wr(4'h5, 8'h80);
        wr(4'h2, 8'h80);
        wr(4'h5, 8'h00);
        wait_tick(t0); wait_tick(t1); check(t1, 128);
        wr(4'h1, 8'h1f);
        repeat (40) @(posedge mclk_i);
        wait_tick(t0); check(t0, 600);
        wr(4'h1, 8'h81);
        wait_tick(t0); wait_tick(t1); check(t1, 128);
        $display("rate test done");
    endtask
    task automatic t_irq;
        wr(4'h9, 8'h01);
        wait_tick(t0);
        repeat (3) @(posedge mclk_i);
        check(irq_o, 1'b1);
        wr(4'h9, 8'h00);
        repeat (2) @(posedge mclk_i);
        check(irq_o, 1'b0);
        wr(4'h8, 8'h01);
        rd(4'h8); check(v, 8'h00);
        $display("irq test done");
    endtask
    task automatic t_rx;
        i_peer.drive(1'b0);
        repeat (3) @(posedge mclk_i);
        check(rx_line_o, 1'b1);
        rd(4'h8); check(v[1], 1'b0);
        i_peer.drive(1'b1);
        wr(4'h3, 8'h0c);
        repeat (3) @(posedge mclk_i);
        check(rx_line_o, 1'b1);
        i_peer.drive(1'b0);
        repeat (3) @(posedge mclk_i);
        check(rx_line_o, 1'b0);
        i_peer.drive(1'b1);
        rd(4'h8); check(v[1], 1'b1);
        $display("rx test done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Main sequence after six cycles of reset.
    initial begin
        repeat (6) @(posedge mclk_i);
        rstn_i <= 1'b1;
        t_regs;
        t_rate;
        t_irq;
        t_rx;
        finish_test;
    end
    // Watchdog well beyond the few thousand cycles the tests need.
    initial begin
        repeat (20000) @(posedge mclk_i);
        n_mismatch++;
        finish_test;
    end
endmodule
`default_nettype wire
